// ===== rtl/mct_pkg.sv
// constants, types and helpers shared by the match/capture timer files
// assumes a single 100 MHz clock domain and an AXI4-Lite register port
package mct_pkg;

    localparam int CH = 4;                    // match and capture channels
    localparam int AW = 8;                    // register address bits used

    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [AW-1:0] OFS_CTRL = 8'h00; // enable, counter reset
    localparam logic [AW-1:0] OFS_TC = 8'h04;   // timer count
    localparam logic [AW-1:0] OFS_PR = 8'h08;   // prescale limit
    localparam logic [AW-1:0] OFS_PC = 8'h0c;   // prescale count, read only
    localparam logic [AW-1:0] OFS_MCR = 8'h10;  // match actions
    localparam logic [AW-1:0] OFS_MR0 = 8'h14;  // match values, 4 words
    localparam logic [AW-1:0] OFS_CCR = 8'h24;  // capture edges and irq
    localparam logic [AW-1:0] OFS_CR0 = 8'h28;  // capture values, 4 words
    localparam logic [AW-1:0] OFS_EMR = 8'h38;  // output state and actions
    localparam logic [AW-1:0] OFS_IST = 8'h3c;  // irq status, read only
    localparam logic [AW-1:0] OFS_ICLR = 8'h40; // irq clear, write only
    localparam logic [AW-1:0] OFS_IEN = 8'h44;  // irq enable
    localparam logic [AW-1:0] OFS_CSEL = 8'h48; // capture pin routing
    localparam logic [AW-1:0] OFS_OSEL = 8'h4c; // output pin routing
    localparam logic [AW-1:0] OFS_LAST = 8'h4c;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_RST = 1;
    localparam int MCR_INT = 0;
    localparam int MCR_RST = 1;
    localparam int MCR_STOP = 2;
    localparam int MCR_STRIDE = 3;
    localparam int CCR_RISE = 0;
    localparam int CCR_FALL = 1;
    localparam int CCR_INT = 2;
    localparam int CCR_STRIDE = 3;
    localparam int EMR_ACT_LSB = 4;
    localparam int EMR_STRIDE = 2;
    localparam int CSEL_AND = 4;
    localparam int CSEL_STRIDE = 8;
    localparam int OSEL_STRIDE = 2;
    localparam int IST_CAP_LSB = 4;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        EM_NONE = 2'b00,
        EM_LOW = 2'b01,
        EM_HIGH = 2'b10,
        EM_TOGGLE = 2'b11
    } mct_emact_type;

    // gray along idle -> ack -> resp
    typedef enum logic [1:0] {
        BS_IDLE = 2'b00,
        BS_ACK = 2'b01,
        BS_RESP = 2'b11
    } mct_bus_state_type;

    typedef struct packed {
        logic en;
        logic [AW-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } mct_wr_type;

    // aligned and inside the map
    function automatic logic addr_ok(input logic [AW-1:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= OFS_LAST);
    endfunction

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        wmerge = r;
    endfunction

endpackage

// ===== rtl/mct_axil_slave.sv
// AXI4-Lite slave front end for the match/capture timer
// assumes the master holds valid and payload until taken; runs on core_clk
`timescale 1ns/100ps
`default_nettype none
module mct_axil_slave import mct_pkg::*; (
    input wire logic clk,                 // core clock
    input wire logic rst_n,               // synchronised reset
    input wire logic [AW-1:0] awaddr,     // write address
    input wire logic awvalid,             // write address valid
    output logic awready,                 // write address taken
    input wire logic [31:0] wdata,        // write data
    input wire logic [3:0] wstrb,         // byte enables
    input wire logic wvalid,              // write data valid
    output logic wready,                  // write data taken
    output logic [1:0] bresp,             // write response
    output logic bvalid,                  // write response valid
    input wire logic bready,              // master takes response
    input wire logic [AW-1:0] araddr,     // read address
    input wire logic arvalid,             // read address valid
    output logic arready,                 // read address taken
    output logic [31:0] rdata,            // read data
    output logic [1:0] rresp,             // read response
    output logic rvalid,                  // read data valid
    input wire logic rready,              // master takes read data
    input wire logic [31:0] rd_word,      // register mux at araddr
    output mct_wr_type wr                 // one-cycle write strobe
);
    mct_bus_state_type wst_r;
    mct_bus_state_type rst_r;

    // --------------------------------------------------------------
    // write channel
    // --------------------------------------------------------------
    // waits for address and data together so one edge takes both
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wst_r <= BS_IDLE;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            case (wst_r)
                BS_IDLE: begin
                    if (awvalid && wvalid) begin
                        wst_r <= BS_ACK;
                    end
                end
                BS_ACK: begin
                    wst_r <= BS_RESP;
                    bvalid <= 1'b1;
                    bresp <= addr_ok(awaddr) ? RESP_OKAY : RESP_SLVERR;
                end
                BS_RESP: begin
                    if (bready) begin
                        wst_r <= BS_IDLE;
                        bvalid <= 1'b0;
                    end
                end
                default: wst_r <= BS_IDLE;
            endcase
        end
    end

    assign awready = (wst_r == BS_ACK);
    assign wready = (wst_r == BS_ACK);
    assign wr.en = (wst_r == BS_ACK) && addr_ok(awaddr);
    assign wr.addr = awaddr;
    assign wr.data = wdata;
    assign wr.strb = wstrb;

    // --------------------------------------------------------------
    // read channel
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_r <= BS_IDLE;
            rvalid <= 1'b0;
            rdata <= RST_WORD;
            rresp <= RESP_OKAY;
        end else begin
            case (rst_r)
                BS_IDLE: begin
                    if (arvalid) begin
                        rst_r <= BS_ACK;
                    end
                end
                BS_ACK: begin
                    rst_r <= BS_RESP;
                    rvalid <= 1'b1;
                    rdata <= addr_ok(araddr) ? rd_word : RST_WORD;
                    rresp <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
                end
                BS_RESP: begin
                    if (rready) begin
                        rst_r <= BS_IDLE;
                        rvalid <= 1'b0;
                    end
                end
                default: rst_r <= BS_IDLE;
            endcase
        end
    end

    assign arready = (rst_r == BS_ACK);

endmodule
`default_nettype wire

// ===== rtl/mct_timer.sv
// match/capture timer: prescaled 32-bit count, four match and four capture
// channels, pin routing, sticky interrupts, AXI4-Lite registers
// assumes capture pins are asynchronous; outputs drive pins directly
//
// Behaviour
// - 32-bit count paced by 32-bit prescaler
// - four match values compared with count
// - match continues, stops or resets; optional irq
// - four captures latch count on edge; optional irq
// - match pins go low, high, toggle, hold
// - pins combine OR/AND, outputs broadcast
`timescale 1ns/100ps
`default_nettype none
module mct_timer import mct_pkg::*; (
    input wire logic core_clk,            // 100 MHz clock
    input wire logic nrst,                // async reset, active low
    input wire logic [AW-1:0] s_awaddr,   // write address
    input wire logic s_awvalid,           // write address valid
    output logic s_awready,               // write address taken
    input wire logic [31:0] s_wdata,      // write data
    input wire logic [3:0] s_wstrb,       // byte enables
    input wire logic s_wvalid,            // write data valid
    output logic s_wready,                // write data taken
    output logic [1:0] s_bresp,           // write response
    output logic s_bvalid,                // write response valid
    input wire logic s_bready,            // response taken
    input wire logic [AW-1:0] s_araddr,   // read address
    input wire logic s_arvalid,           // read address valid
    output logic s_arready,               // read address taken
    output logic [31:0] s_rdata,          // read data
    output logic [1:0] s_rresp,           // read response
    output logic s_rvalid,                // read data valid
    input wire logic s_rready,            // read data taken
    input wire logic [CH-1:0] cap_pin,    // capture pins, async
    output logic [CH-1:0] match_pin,      // match output pins
    output logic irq                      // level interrupt
);
    logic rst_sync1_r;
    logic rst_n;
    mct_wr_type wr;
    logic [31:0] rd_word;
    logic [31:0] ctrl_r, pr_r, mcr_r, ccr_r, emr_r, ien_r, csel_r, osel_r;
    logic [31:0] tc_r, pc_r;
    logic [31:0] mr_r [CH];
    logic [31:0] cr_r [CH];
    logic [2*CH-1:0] ist_r;
    logic [CH-1:0] cap_s1_r, cap_s2_r, comb, comb_prev_r, cap_hit;
    logic [CH-1:0] m_hit, m_rst, m_stop, m_int, c_int;
    logic tick;

    // --------------------------------------------------------------
    // reset release
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_n <= rst_sync1_r;
        end
    end

    mct_axil_slave u_bus (
        .clk(core_clk),
        .rst_n(rst_n),
        .awaddr(s_awaddr),
        .awvalid(s_awvalid),
        .awready(s_awready),
        .wdata(s_wdata),
        .wstrb(s_wstrb),
        .wvalid(s_wvalid),
        .wready(s_wready),
        .bresp(s_bresp),
        .bvalid(s_bvalid),
        .bready(s_bready),
        .araddr(s_araddr),
        .arvalid(s_arvalid),
        .arready(s_arready),
        .rdata(s_rdata),
        .rresp(s_rresp),
        .rvalid(s_rvalid),
        .rready(s_rready),
        .rd_word(rd_word),
        .wr(wr)
    );

    // --------------------------------------------------------------
    // per-channel match and capture terms
    // --------------------------------------------------------------
    // prescaler limit tick
    assign tick = ctrl_r[CTRL_EN] && !ctrl_r[CTRL_RST] && (pc_r == pr_r);

    for (genvar i = 0; i < CH; i++) begin : g_ch
        assign m_hit[i] = tick && (tc_r == mr_r[i]);
        assign m_rst[i] = m_hit[i] && mcr_r[i*MCR_STRIDE + MCR_RST];
        assign m_stop[i] = m_hit[i] && mcr_r[i*MCR_STRIDE + MCR_STOP];
        assign m_int[i] = m_hit[i] && mcr_r[i*MCR_STRIDE + MCR_INT];
        // OR or AND over the selected capture pins
        assign comb[i] = csel_r[i*CSEL_STRIDE + CSEL_AND]
            ? &(cap_s2_r | ~csel_r[i*CSEL_STRIDE +: CH])
            : |(cap_s2_r & csel_r[i*CSEL_STRIDE +: CH]);
        assign cap_hit[i] =
            (comb[i] && !comb_prev_r[i] && ccr_r[i*CCR_STRIDE + CCR_RISE])
            || (!comb[i] && comb_prev_r[i]
                && ccr_r[i*CCR_STRIDE + CCR_FALL]);
        assign c_int[i] = cap_hit[i] && ccr_r[i*CCR_STRIDE + CCR_INT];

        // two-stage synchroniser for each capture pin
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cap_s1_r[i] <= 1'b0;
                cap_s2_r[i] <= 1'b0;
                comb_prev_r[i] <= 1'b0;
            end else begin
                cap_s1_r[i] <= cap_pin[i];
                cap_s2_r[i] <= cap_s1_r[i];
                comb_prev_r[i] <= comb[i];
            end
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cr_r[i] <= RST_WORD;
            end else if (cap_hit[i]) begin
                cr_r[i] <= tc_r;
            end
        end

        // match value registers
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                mr_r[i] <= RST_WORD;
            end else if (wr.en && wr.addr == OFS_MR0 + AW'(4 * i)) begin
                mr_r[i] <= wmerge(mr_r[i], wr.data, wr.strb);
            end
        end

        // external output action on match; hardware beats software
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                emr_r[i] <= 1'b0;
            end else if (m_hit[i]) begin
                case (mct_emact_type'(emr_r[EMR_ACT_LSB + i*EMR_STRIDE +:
                                            EMR_STRIDE]))
                    EM_LOW: emr_r[i] <= 1'b0;
                    EM_HIGH: emr_r[i] <= 1'b1;
                    EM_TOGGLE: emr_r[i] <= !emr_r[i];
                    default: emr_r[i] <= emr_r[i];
                endcase
            end else if (wr.en && wr.addr == OFS_EMR && wr.strb[0]) begin
                emr_r[i] <= wr.data[i];
            end
        end

        // each pin follows any one match output, so one can broadcast
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                match_pin[i] <= 1'b0;
            end else begin
                match_pin[i] <= emr_r[osel_r[i*OSEL_STRIDE +: OSEL_STRIDE]];
            end
        end
    end

    // --------------------------------------------------------------
    // counter and prescaler
    // --------------------------------------------------------------
    // prescaled timer count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tc_r <= RST_WORD;
            pc_r <= RST_WORD;
        end else if (ctrl_r[CTRL_RST]) begin
            tc_r <= RST_WORD;
            pc_r <= RST_WORD;
        end else if (wr.en && wr.addr == OFS_TC) begin
            tc_r <= wmerge(tc_r, wr.data, wr.strb);
        end else if (tick) begin
            pc_r <= RST_WORD;
            // reset on match wins over the increment
            tc_r <= (|m_rst) ? RST_WORD : tc_r + 32'h0000_0001;
        end else if (ctrl_r[CTRL_EN]) begin
            pc_r <= pc_r + 32'h0000_0001;
        end
    end

    // --------------------------------------------------------------
    // control and configuration registers
    // --------------------------------------------------------------
    // stop on match clears the enable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= RST_WORD;
        end else if (|m_stop) begin
            ctrl_r[CTRL_EN] <= 1'b0;
        end else if (wr.en && wr.addr == OFS_CTRL) begin
            ctrl_r <= wmerge(ctrl_r, wr.data, wr.strb) & 32'h0000_0003;
        end
    end

    // plain read/write configuration words
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pr_r <= RST_WORD;
            mcr_r <= RST_WORD;
            ccr_r <= RST_WORD;
            ien_r <= RST_WORD;
            csel_r <= RST_WORD;
            osel_r <= RST_WORD;
            emr_r[31:CH] <= '0;
        end else if (wr.en) begin
            case (wr.addr)
                OFS_PR: pr_r <= wmerge(pr_r, wr.data, wr.strb);
                OFS_MCR: mcr_r <= wmerge(mcr_r, wr.data, wr.strb);
                OFS_CCR: ccr_r <= wmerge(ccr_r, wr.data, wr.strb);
                OFS_IEN: ien_r <= wmerge(ien_r, wr.data, wr.strb);
                OFS_CSEL: csel_r <= wmerge(csel_r, wr.data, wr.strb);
                OFS_OSEL: osel_r <= wmerge(osel_r, wr.data, wr.strb);
                OFS_EMR: emr_r[31:CH] <=
                    (32-CH)'(wmerge(emr_r, wr.data, wr.strb) >> CH);
                default: pr_r <= pr_r;
            endcase
        end
    end

    // --------------------------------------------------------------
    // interrupts
    // --------------------------------------------------------------
    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ist_r <= '0;
        end else begin
            ist_r <= (ist_r & ~((wr.en && wr.addr == OFS_ICLR)
                                ? wr.data[2*CH-1:0] : '0))
                     | {c_int, m_int};
        end
    end

    // registered level output, one cycle behind the status
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ist_r & ien_r[2*CH-1:0]);
        end
    end

    // --------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------
    always_comb begin
        rd_word = RST_WORD;
        case (s_araddr)
            OFS_CTRL: rd_word = ctrl_r;
            OFS_TC: rd_word = tc_r;
            OFS_PR: rd_word = pr_r;
            OFS_PC: rd_word = pc_r;
            OFS_MCR: rd_word = mcr_r;
            OFS_CCR: rd_word = ccr_r;
            OFS_EMR: rd_word = emr_r;
            OFS_IST: rd_word = {24'h00_0000, ist_r};
            OFS_IEN: rd_word = ien_r;
            OFS_CSEL: rd_word = csel_r;
            OFS_OSEL: rd_word = osel_r;
            default: begin
                for (int k = 0; k < CH; k++) begin
                    if (s_araddr == OFS_MR0 + AW'(4 * k)) begin
                        rd_word = mr_r[k];
                    end
                    if (s_araddr == OFS_CR0 + AW'(4 * k)) begin
                        rd_word = cr_r[k];
                    end
                end
            end
        endcase
    end

endmodule
`default_nettype wire

// ===== tb/mct_timer_chk.sv
// port-level checker for the match/capture timer
// assumes one core_clk domain; bound to every mct_timer
`timescale 1ns/100ps
`default_nettype none
module mct_timer_chk import mct_pkg::*; (
    input wire logic core_clk,      // clock
    input wire logic nrst,          // reset, active low
    input wire logic s_awvalid,     // write address valid
    input wire logic s_wvalid,      // write data valid
    input wire logic s_awready,     // write address taken
    input wire logic s_wready,      // write data taken
    input wire logic s_bvalid,      // write response valid
    input wire logic s_bready,      // response taken
    input wire logic [1:0] s_bresp, // write response
    input wire logic s_arvalid,     // read address valid
    input wire logic s_arready,     // read address taken
    input wire logic s_rvalid,      // read data valid
    input wire logic s_rready,      // read data taken
    input wire logic [31:0] s_rdata, // read data
    input wire logic [1:0] s_rresp, // read response
    input wire logic irq            // level interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // register port handshakes
    // ------------------------------------------------------------
    property p_aw_pair;
        s_awready |-> s_wready && s_awvalid && s_wvalid; endproperty
    a_aw_pair: assert property (p_aw_pair)
        else $error("write taken without both valids");
    property p_b_follow; s_awready |=> s_bvalid && !s_awready; endproperty
    a_b_follow: assert property (p_b_follow)
        else $error("no write response after take");
    property p_b_hold;
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_b_done; s_bvalid && s_bready |=> !s_bvalid; endproperty
    a_b_done: assert property (p_b_done)
        else $error("write response held after accept");
    property p_ar_r; s_arready |-> s_arvalid ##1 s_rvalid; endproperty
    a_ar_r: assert property (p_ar_r)
        else $error("read answer late or unrequested");
    property p_r_hold;
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data changed before accept");
    property p_r_err;
        s_rvalid && s_rresp == RESP_SLVERR |-> s_rdata == RST_WORD; endproperty
    a_r_err: assert property (p_r_err)
        else $error("refused read returned data");
    // interrupt only drops after a register write
    property p_irq_drop; $fell(irq) |-> $past(s_awready, 2); endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("interrupt dropped without a write");
endmodule
bind mct_timer mct_timer_chk i_mct_timer_chk (.core_clk, .nrst, .s_awvalid,
    .s_wvalid, .s_awready, .s_wready, .s_bvalid, .s_bready, .s_bresp,
    .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata, .s_rresp, .irq);
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the match/capture timer
// assumes the designer's bus timing; bench drives every port itself
`timescale 1ns/100ps
`default_nettype none
module tb import mct_pkg::*;;
    logic core_clk, nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
    logic [AW-1:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, v;
    logic [3:0] s_wstrb, cap_pin, match_pin;
    logic [1:0] s_bresp, s_rresp;
    logic [1:0] acts[4] = '{EM_LOW, EM_HIGH, EM_TOGGLE, EM_NONE};
    logic ini[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic fin[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [33:0] exp_q[$];
    string nam_q[$];
    int n_errors, comparisons, cyc, t1, seed;

    mct_timer i_mct_timer (.core_clk, .nrst, .s_awaddr, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready, .cap_pin, .match_pin, .irq);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic chk(input string nm, input logic [33:0] e,
                       input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one bus transfer; response is late on purpose so valid waits
    task automatic acc(input bit w, input logic [7:0] a,
                       input logic [31:0] d, input logic [1:0] r,
                       input string nm);
        @(posedge core_clk);
        exp_q.push_back({w ? 32'h0 : d, r});
        nam_q.push_back(nm);
        s_awaddr <= a;
        s_araddr <= a;
        s_wdata <= d;
        s_awvalid <= w;
        s_wvalid <= w;
        s_arvalid <= !w;
        do @(posedge core_clk); while ((w ? s_awready : s_arready) !== 1'b1);
        s_awvalid <= 1'b0;
        s_wvalid <= 1'b0;
        s_arvalid <= 1'b0;
        do @(posedge core_clk); while ((w ? s_bvalid : s_rvalid) !== 1'b1);
        s_bready <= w;
        s_rready <= !w;
        @(posedge core_clk);
        s_bready <= 1'b0;
        s_rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, RESP_OKAY, "bresp");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, string nm);
        acc(1'b0, a, d, RESP_OKAY, nm);
    endtask

    // oldest note is matched against each accepted response
    always @(posedge core_clk) begin
        if ((s_bvalid & s_bready | s_rvalid & s_rready) === 1'b1 &&
            exp_q.size() > 0) begin
            chk(nam_q.pop_front(), exp_q.pop_front(),
                {s_bvalid ? 32'h0 : s_rdata, s_bvalid ? s_bresp : s_rresp});
        end
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs about six hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        results;
    end

    initial begin
        seed = 32'hc340a58c;
        {nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= '0;
        {s_awaddr, s_araddr, s_wdata, cap_pin} <= '0;
        s_wstrb <= 4'hf;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(OFS_CTRL, 32'h0, "ctrl reset");
        rd(OFS_TC, 32'h0, "tc reset");
        acc(1'b0, 8'h50, 32'h0, RESP_SLVERR, "unmapped read");
        acc(1'b1, 8'h50, 32'h5, RESP_SLVERR, "unmapped write");
        $display("test reset done");
        wr(OFS_PR, 32'h3);
        wr(OFS_MR0, 32'h5);
        wr(OFS_MCR, 32'h3);
        wr(OFS_IEN, 32'hf1);
        wr(OFS_CTRL, 32'h1);
        do @(posedge core_clk); while (irq !== 1'b1);
        t1 = cyc;
        wr(OFS_ICLR, 32'hff);
        do @(posedge core_clk); while (irq !== 1'b1);
        chk("period", 34'd24, 34'(cyc - t1));
        rd(OFS_IST, 32'h1, "match status");
        wr(OFS_MCR, 32'h6);
        repeat (40) @(posedge core_clk);
        $display("test prescale period done");
        for (int k = 0; k < 4; k++) begin
            wr(OFS_EMR, {26'h0, acts[k], 3'b000, ini[k]});
            wr(OFS_CTRL, 32'h1);
            repeat (40) @(posedge core_clk);
            rd(OFS_EMR, {26'h0, acts[k], 3'b000, fin[k]}, "output");
            rd(OFS_CTRL, 32'h0, "stopped");
            chk("match_pin", {30'h0, {4{fin[k]}}}, {30'h0, match_pin});
        end
        wr(OFS_OSEL, 32'h4);
        chk("routed pins", 34'hd, {30'h0, match_pin});
        $display("test match outputs done");
        wr(OFS_ICLR, 32'hff);
        wr(OFS_CSEL, 32'h08040201);
        wr(OFS_CCR, 32'hb6d);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(OFS_TC, v);
            cap_pin[i] <= 1'b1;
            repeat (6) @(posedge core_clk);
            rd(OFS_CR0 + 8'(4 * i), v, "capture");
            cap_pin[i] <= 1'b0;
        end
        rd(OFS_IST, 32'hf0, "capture status");
        chk("irq", 34'h1, {33'h0, irq});
        wr(OFS_ICLR, 32'hff);
        wr(OFS_CSEL, 32'h13);
        cap_pin[1] <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(OFS_IST, 32'h0, "and one pin");
        cap_pin[0] <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(OFS_IST, 32'h10, "and both pins");
        wr(OFS_ICLR, 32'hff);
        wr(OFS_CCR, 32'h6);
        cap_pin[1] <= 1'b0;
        repeat (6) @(posedge core_clk);
        rd(OFS_IST, 32'h10, "falling edge");
        wr(OFS_CTRL, 32'h3);
        rd(OFS_TC, 32'h0, "counter held");
        rd(OFS_PC, 32'h0, "prescaler held");
        $display("test captures done");
        results;
    end
endmodule
`default_nettype wire
